//--- src/pump_seq_pkg.sv
package pump_seq_pkg;

  // clock and timing
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
  localparam int unsigned LOW_HOLD_MS     = 200;
  localparam int unsigned LOW_HOLD_CYCLES = CYC_PER_MS * LOW_HOLD_MS;
  localparam int unsigned BEEP_MS         = 100;
  localparam int unsigned BEEP_CYCLES     = CYC_PER_MS * BEEP_MS;
  localparam int unsigned CNT_W           = 23;

  // program layout
  localparam int unsigned PHASE_W     = 7;
  localparam int unsigned ARG_W       = 8;
  localparam int unsigned MODE_W      = 8;
  localparam logic [6:0]  FIRST_PHASE = 7'h01;
  localparam logic [6:0]  MAX_PHASE   = 7'h63;
  localparam int unsigned OUT_BIT     = 0;

  // reset values
  localparam logic [6:0] PHASE_RST    = 7'h01;
  localparam logic [7:0] MODE_RST     = 8'h00;
  localparam logic       PROG_OUT_RST = 1'b0;

  typedef enum logic [3:0] {
    OP_PUMP        = 4'h0,
    OP_COND_JUMP   = 4'h1,
    OP_LEVEL_TRAP  = 4'h2,
    OP_ANY_TRAP    = 4'h3,
    OP_TRAP_DISARM = 4'h4,
    OP_CLEAR_TOTAL = 4'h5,
    OP_TRIG_MODE   = 4'h6,
    OP_REDIRECT    = 4'h7,
    OP_SET_OUTPUT  = 4'h8,
    OP_BEEP        = 4'h9,
    OP_JUMP        = 4'ha,
    OP_STOP        = 4'hb
  } op_t;

  typedef enum logic [1:0] {
    TRAP_NONE       = 2'b00,
    TRAP_LEVEL_EDGE = 2'b01,
    TRAP_ANY_EDGE   = 2'b10
  } trap_mode_t;

  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_FETCH = 2'b01,
    S_EXEC  = 2'b10,
    S_PUMP  = 2'b11
  } seq_state_t;

endpackage : pump_seq_pkg

//--- src/trig_watch_if.sv
`timescale 1ns/100ps
`default_nettype none
interface trig_watch_if;
  logic rise;
  logic fall;
  logic lowHeld;
  modport watch (output rise, output fall, output lowHeld);
  modport seq   (input rise, input fall, input lowHeld);
endinterface : trig_watch_if
`default_nettype wire

//--- src/trig_watch.sv
`timescale 1ns/100ps
`default_nettype none
module trig_watch #(
  parameter int unsigned LowHoldCycles = pump_seq_pkg::LOW_HOLD_CYCLES
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  // event trigger pin
  input  wire logic       eventTrigPin,
  // edges and hold level
  trig_watch_if.watch     trig
);

  logic                          syncA_q;
  logic                          syncB_q;
  logic                          prev_q;
  logic [pump_seq_pkg::CNT_W-1:0] lowCnt_q;
  logic [pump_seq_pkg::CNT_W-1:0] holdLim;

  assign holdLim = pump_seq_pkg::CNT_W'(LowHoldCycles);

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      syncA_q <= 1'b1;
      syncB_q <= 1'b1;
      prev_q  <= 1'b1;
    end else begin
      syncA_q <= eventTrigPin;
      syncB_q <= syncA_q;
      prev_q  <= syncB_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      lowCnt_q <= '0;
    end else if (syncB_q) begin
      lowCnt_q <= '0;
    end else if (lowCnt_q < holdLim) begin
      lowCnt_q <= lowCnt_q + 1'b1;
    end
  end

  assign trig.rise    = syncB_q & ~prev_q;
  assign trig.fall    = ~syncB_q & prev_q;
  assign trig.lowHeld = ~syncB_q && (lowCnt_q >= holdLim);

endmodule : trig_watch
`default_nettype wire

//--- src/beep_timer.sv
`timescale 1ns/100ps
`default_nettype none
module beep_timer #(
  parameter int unsigned BeepCycles = pump_seq_pkg::BEEP_CYCLES
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rstn,
  // control
  input  wire logic start,
  output var  logic buzzer
);

  logic [pump_seq_pkg::CNT_W-1:0] left_q;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      left_q <= '0;
      buzzer <= 1'b0;
    end else if (start) begin
      left_q <= pump_seq_pkg::CNT_W'(BeepCycles);
      buzzer <= 1'b1;
    end else if (left_q > 1) begin
      left_q <= left_q - 1'b1;
    end else begin
      left_q <= '0;
      buzzer <= 1'b0;
    end
  end

endmodule : beep_timer
`default_nettype wire

//--- src/pump_program_event_sequencer.sv
// What this block does
// - conditional jump taken when program input low
// - setup arms one-shot trap with target
// - level/edge trap fires on falling edge
// - level/edge fires at setup if input already held low 200ms
// - remote event command fires armed trap
// - firing aborts operation, jumps to target
// - trap disarmed after it fires
// - new setup replaces existing trap
// - any-edge trap fires on both edges, remote
// - clear both dispensed volume totals
// - override sets operational trigger mode
// - program start uses stored default mode
// - redirected stop trigger fires armed trap
// - redirected stop, no trap: next phase
// - redirection cleared by trap firing or program start; firing leaves trigger mode untouched
// - set output pin to parameter level
// - beep briefly then proceed
// - unconditional jump to target phase
`timescale 1ns/100ps
`default_nettype none
module pump_program_event_sequencer #(
  parameter int unsigned LowHoldCycles = pump_seq_pkg::LOW_HOLD_CYCLES,
  parameter int unsigned BeepCycles    = pump_seq_pkg::BEEP_CYCLES
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  // program control from keypad or host
  input  wire logic       progStart,
  input  wire logic       progStop,
  input  wire logic       remoteEvent,
  input  wire logic [7:0] defaultTrigMode,
  // program memory
  output var  logic [6:0] fetchPhase,
  input  wire logic [3:0] instrOp,
  input  wire logic [7:0] instrArg,
  // pump operation handshake
  output var  logic       opStart,
  input  wire logic       opDone,
  output var  logic       pumpAbort,
  input  wire logic       opTrigStop,
  output var  logic [7:0] trigMode,
  // totals and status
  output var  logic       clearTotals,
  output var  logic       running,
  // ttl pins and buzzer
  input  wire logic       eventTrigPin,
  input  wire logic       progInPin,
  output var  logic       progOutPin,
  output var  logic       buzzer
);

  pump_seq_pkg::seq_state_t state_q;
  pump_seq_pkg::seq_state_t state_d;
  pump_seq_pkg::trap_mode_t trapMode_q;
  logic [6:0]               phase_q;
  logic [6:0]               phase_d;
  logic [6:0]               target_q;
  logic                     redirect_q;
  logic                     progInA_q;
  logic                     progInB_q;
  logic                     beepStart_q;
  pump_seq_pkg::op_t        op;
  logic [6:0]               argPhase;
  logic                     active;
  logic                     armed;
  logic                     edgeHit;
  logic                     redirStop;
  logic                     fire;
  logic                     advance;
  logic                     setupNow;
  logic                     setupFire;
  logic                     plainStop;

  trig_watch_if trig ();

  trig_watch #(
    .LowHoldCycles(LowHoldCycles)
  ) u_watch (
    .clk_sys      (clk_sys),
    .rstn         (rstn),
    .eventTrigPin (eventTrigPin),
    .trig         (trig.watch)
  );

  beep_timer #(
    .BeepCycles(BeepCycles)
  ) u_beep (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .start   (beepStart_q),
    .buzzer  (buzzer)
  );

  // next phase after the current one
  function automatic logic [6:0] stepPhase(input logic [6:0] p);
    stepPhase = p + 7'h01;
  endfunction : stepPhase

  // target of a jump, taken from the parameter
  function automatic logic [6:0] toPhase(input logic [7:0] a);
    toPhase = a[6:0];
  endfunction : toPhase

  // program input pin synchroniser
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      progInA_q <= 1'b1;
      progInB_q <= 1'b1;
    end else begin
      progInA_q <= progInPin;
      progInB_q <= progInA_q;
    end
  end

  assign op       = pump_seq_pkg::op_t'(instrOp);
  assign argPhase = toPhase(instrArg);
  assign active   = (state_q != pump_seq_pkg::S_IDLE);
  assign armed    = (trapMode_q != pump_seq_pkg::TRAP_NONE);

  // event trigger sources
  always_comb begin
    case (trapMode_q)
      pump_seq_pkg::TRAP_LEVEL_EDGE: edgeHit = trig.fall;
      pump_seq_pkg::TRAP_ANY_EDGE:   edgeHit = trig.rise | trig.fall;
      default:                       edgeHit = 1'b0;
    endcase
  end

  assign setupNow  = (state_q == pump_seq_pkg::S_EXEC) &&
                     (op == pump_seq_pkg::OP_LEVEL_TRAP);
  // already held low when setup executes
  assign setupFire = setupNow && trig.lowHeld;
  assign redirStop = active && opTrigStop && redirect_q;
  assign fire      = active && armed &&
                     (edgeHit || remoteEvent || redirStop);
  // redirected stop with no trap armed
  assign advance   = redirStop && !armed;
  assign plainStop = active && opTrigStop && !redirect_q;

  // sequencer state and phase
  always_comb begin
    state_d = state_q;
    phase_d = phase_q;
    case (state_q)
      pump_seq_pkg::S_IDLE: begin
        if (progStart) begin
          state_d = pump_seq_pkg::S_FETCH;
          phase_d = pump_seq_pkg::FIRST_PHASE;
        end
      end
      pump_seq_pkg::S_FETCH: begin
        state_d = pump_seq_pkg::S_EXEC;
      end
      pump_seq_pkg::S_EXEC: begin
        state_d = pump_seq_pkg::S_FETCH;
        phase_d = stepPhase(phase_q);
        case (op)
          pump_seq_pkg::OP_PUMP: begin
            state_d = pump_seq_pkg::S_PUMP;
            phase_d = phase_q;
          end
          pump_seq_pkg::OP_COND_JUMP: begin
            // branch when program input is low
            if (!progInB_q) begin
              phase_d = argPhase;
            end
          end
          pump_seq_pkg::OP_LEVEL_TRAP: begin
            // immediate jump to the new target
            if (setupFire) begin
              phase_d = argPhase;
            end
          end
          pump_seq_pkg::OP_JUMP: begin
            phase_d = argPhase;
          end
          pump_seq_pkg::OP_STOP: begin
            state_d = pump_seq_pkg::S_IDLE;
            phase_d = pump_seq_pkg::FIRST_PHASE;
          end
          default: begin
          end
        endcase
      end
      pump_seq_pkg::S_PUMP: begin
        if (opDone) begin
          state_d = pump_seq_pkg::S_FETCH;
          phase_d = stepPhase(phase_q);
        end
      end
      default: begin
        state_d = pump_seq_pkg::S_IDLE;
      end
    endcase
    // trap jumps to target, abandoning the phase
    if (fire) begin
      state_d = pump_seq_pkg::S_FETCH;
      phase_d = target_q;
    end else if (advance) begin
      state_d = pump_seq_pkg::S_FETCH;
      phase_d = stepPhase(phase_q);
    end else if (plainStop) begin
      state_d = pump_seq_pkg::S_IDLE;
      phase_d = pump_seq_pkg::FIRST_PHASE;
    end
    // past the last phase acts as stop
    if (state_d == pump_seq_pkg::S_FETCH &&
        (phase_d > pump_seq_pkg::MAX_PHASE ||
         phase_d == 7'h00)) begin
      state_d = pump_seq_pkg::S_IDLE;
      phase_d = pump_seq_pkg::FIRST_PHASE;
    end
    if (progStop && active) begin
      state_d = pump_seq_pkg::S_IDLE;
      phase_d = pump_seq_pkg::FIRST_PHASE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state_q <= pump_seq_pkg::S_IDLE;
      phase_q <= pump_seq_pkg::PHASE_RST;
    end else begin
      state_q <= state_d;
      phase_q <= phase_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      fetchPhase <= pump_seq_pkg::PHASE_RST;
      running    <= 1'b0;
    end else begin
      fetchPhase <= phase_d;
      running    <= (state_d != pump_seq_pkg::S_IDLE);
    end
  end

  // event trap arming
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      trapMode_q <= pump_seq_pkg::TRAP_NONE;
      target_q   <= pump_seq_pkg::PHASE_RST;
    end else if (state_q == pump_seq_pkg::S_EXEC && !fire &&
                 !progStop) begin
      case (op)
        pump_seq_pkg::OP_LEVEL_TRAP: begin
          trapMode_q <= setupFire ? pump_seq_pkg::TRAP_NONE
                                  : pump_seq_pkg::TRAP_LEVEL_EDGE;
          target_q   <= argPhase;
        end
        pump_seq_pkg::OP_ANY_TRAP: begin
          trapMode_q <= pump_seq_pkg::TRAP_ANY_EDGE;
          target_q   <= argPhase;
        end
        pump_seq_pkg::OP_TRAP_DISARM: begin
          trapMode_q <= pump_seq_pkg::TRAP_NONE;
        end
        default: begin
        end
      endcase
    end else if (fire) begin
      trapMode_q <= pump_seq_pkg::TRAP_NONE;
    end
  end

  // stop trigger redirection
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      redirect_q <= 1'b0;
    end else if (progStart && state_q == pump_seq_pkg::S_IDLE) begin
      redirect_q <= 1'b0;
    end else if (fire || setupFire) begin
      // cleared once a trap has fired
      redirect_q <= 1'b0;
    end else if (state_q == pump_seq_pkg::S_EXEC &&
                 op == pump_seq_pkg::OP_REDIRECT) begin
      redirect_q <= 1'b1;
    end
  end

  // operational trigger mode
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      trigMode <= pump_seq_pkg::MODE_RST;
    end else if (state_q == pump_seq_pkg::S_IDLE && progStart) begin
      // start always from the stored default
      trigMode <= defaultTrigMode;
    end else if (state_q == pump_seq_pkg::S_EXEC && !fire &&
                 op == pump_seq_pkg::OP_TRIG_MODE) begin
      trigMode <= instrArg;
    end
  end

  // pump operation strobes
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      opStart   <= 1'b0;
      pumpAbort <= 1'b0;
    end else begin
      opStart   <= (state_q == pump_seq_pkg::S_EXEC) &&
                   (op == pump_seq_pkg::OP_PUMP) &&
                   !fire && !advance && !plainStop && !progStop;
      pumpAbort <= fire || advance || setupFire ||
                   (progStop && active) || plainStop;
    end
  end

  // totals, output pin and beep
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      clearTotals <= 1'b0;
      beepStart_q <= 1'b0;
      progOutPin  <= pump_seq_pkg::PROG_OUT_RST;
    end else begin
      clearTotals <= (state_q == pump_seq_pkg::S_EXEC) && !fire &&
                     (op == pump_seq_pkg::OP_CLEAR_TOTAL);
      beepStart_q <= (state_q == pump_seq_pkg::S_EXEC) && !fire &&
                     (op == pump_seq_pkg::OP_BEEP);
      if (state_q == pump_seq_pkg::S_EXEC && !fire &&
          op == pump_seq_pkg::OP_SET_OUTPUT) begin
        progOutPin <= instrArg[pump_seq_pkg::OUT_BIT];
      end
    end
  end

endmodule : pump_program_event_sequencer
`default_nettype wire

//--- tb/pump_seq_sva.sv
`timescale 1ns/100ps
`default_nettype none
module pump_seq_sva #(
  parameter int unsigned LowHoldCycles = 20,
  parameter int unsigned BeepCycles    = 5
) (
  input wire logic       clk_sys,
  input wire logic       rstn,
  input wire logic       progStart,
  input wire logic       progStop,
  input wire logic [7:0] defaultTrigMode,
  input wire logic [6:0] fetchPhase,
  input wire logic [3:0] instrOp,
  input wire logic [7:0] instrArg,
  input wire logic       opStart,
  input wire logic       pumpAbort,
  input wire logic [7:0] trigMode,
  input wire logic       clearTotals,
  input wire logic       running,
  input wire logic       progOutPin,
  input wire logic       buzzer
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  int unsigned beepCnt_q;
  logic        argBit;
  assign argBit = instrArg[0];

  always_ff @(posedge clk_sys) begin
    if (!rstn || !buzzer) beepCnt_q <= 0;
    else beepCnt_q <= beepCnt_q + 1;
  end

  sequence idleStart;
    !running && progStart;
  endsequence

  a_start_phase: assert property (
    idleStart |=> running && fetchPhase == 7'h01) else $error("bad start");
  a_start_mode: assert property (
    idleStart |=> trigMode == $past(defaultTrigMode))
    else $error("start mode not default");
  a_mode_source: assert property (
    ($changed(trigMode) && $past(rstn)) |->
      ($past(instrOp) == pump_seq_pkg::OP_TRIG_MODE
       && trigMode == $past(instrArg)) || trigMode == $past(defaultTrigMode))
    else $error("trigger mode changed without cause");
  a_out_level: assert property (
    ($changed(progOutPin) && $past(rstn)) |->
      $past(instrOp) == pump_seq_pkg::OP_SET_OUTPUT
      && progOutPin == $past(argBit)) else $error("output pin wrong");
  a_clear_pulse: assert property (
    clearTotals |-> $past(instrOp) == pump_seq_pkg::OP_CLEAR_TOTAL
      ##1 !clearTotals) else $error("clear pulse wrong");
  a_abort_pulse: assert property (
    pumpAbort |=> !pumpAbort) else $error("abort longer than one cycle");
  a_opstart_pulse: assert property (
    opStart |-> running ##1 !opStart) else $error("opStart pulse wrong");
  a_stop_now: assert property (
    running && progStop |=> !running) else $error("stop ignored");
  a_beep_length: assert property (
    ($fell(buzzer) && $past(rstn)) |-> beepCnt_q == BeepCycles)
    else $error("beep length wrong");
endmodule : pump_seq_sva

bind pump_program_event_sequencer pump_seq_sva #(
  .LowHoldCycles(LowHoldCycles), .BeepCycles(BeepCycles)
) u_sva (
  .clk_sys(clk_sys), .rstn(rstn), .progStart(progStart),
  .progStop(progStop), .defaultTrigMode(defaultTrigMode),
  .fetchPhase(fetchPhase), .instrOp(instrOp), .instrArg(instrArg),
  .opStart(opStart), .pumpAbort(pumpAbort), .trigMode(trigMode),
  .clearTotals(clearTotals), .running(running),
  .progOutPin(progOutPin), .buzzer(buzzer)
);
`default_nettype wire

//--- tb/pump_far_model.sv
`timescale 1ns/100ps
`default_nettype none
module pump_far_model (
  // clock
  input  wire logic       clk_sys,
  // program memory
  input  wire logic [6:0] fetchPhase,
  output var  logic [3:0] instrOp,
  output var  logic [7:0] instrArg,
  // pump operation
  input  wire logic       opStart,
  input  wire logic       pumpAbort,
  output var  logic       opDone
);
  logic [3:0] opMem  [128];
  logic [7:0] argMem [128];
  int         opDelay = 0;
  int         left    = 0;

  assign instrOp  = opMem[fetchPhase];
  assign instrArg = argMem[fetchPhase];

  // zero delay means the pump never finishes by itself
  always @(posedge clk_sys) begin
    opDone <= !pumpAbort && !opStart && left == 1;
    if (pumpAbort) left <= 0;
    else if (opStart) left <= opDelay;
    else if (left > 0) left <= left - 1;
  end
endmodule : pump_far_model
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic       clk_sys         = 1'b0;
  logic       rstn            = 1'b0;
  logic       progStart       = 1'b0;
  logic       progStop        = 1'b0;
  logic       remoteEvent     = 1'b0;
  logic       opTrigStop      = 1'b0;
  logic       eventTrigPin    = 1'b1;
  logic       progInPin       = 1'b1;
  logic [7:0] defaultTrigMode = 8'h05;
  logic [6:0] fetchPhase;
  logic [3:0] instrOp;
  logic [7:0] instrArg;
  logic [7:0] trigMode;
  logic       opStart, opDone, pumpAbort, clearTotals;
  logic       running, progOutPin, buzzer;
  int         bad_count = 0;
  int         checked   = 0;
  int         abortCnt, clrCnt, beepCnt;

  always #12.5 clk_sys = ~clk_sys;

  pump_program_event_sequencer #(.LowHoldCycles(20), .BeepCycles(5)) dut (
    .clk_sys(clk_sys), .rstn(rstn), .progStart(progStart),
    .progStop(progStop), .remoteEvent(remoteEvent),
    .defaultTrigMode(defaultTrigMode), .fetchPhase(fetchPhase),
    .instrOp(instrOp), .instrArg(instrArg), .opStart(opStart),
    .opDone(opDone), .pumpAbort(pumpAbort), .opTrigStop(opTrigStop),
    .trigMode(trigMode), .clearTotals(clearTotals), .running(running),
    .eventTrigPin(eventTrigPin), .progInPin(progInPin),
    .progOutPin(progOutPin), .buzzer(buzzer)
  );

  pump_far_model prog (
    .clk_sys(clk_sys), .fetchPhase(fetchPhase), .instrOp(instrOp),
    .instrArg(instrArg), .opStart(opStart), .pumpAbort(pumpAbort),
    .opDone(opDone)
  );

  always @(posedge clk_sys) begin
    if (pumpAbort === 1'b1) abortCnt++;
    if (clearTotals === 1'b1) clrCnt++;
    if (buzzer === 1'b1) beepCnt++;
  end

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    if (bad_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : tick

  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask : pulse

  task automatic ld(input int p, input pump_seq_pkg::op_t op,
                    input logic [7:0] arg);
    prog.opMem[p]  = op;
    prog.argMem[p] = arg;
  endtask : ld

  task automatic doReset(input int n);
    rstn = 1'b0;
    for (int p = 0; p < 128; p++) ld(p, pump_seq_pkg::OP_STOP, 8'h00);
    abortCnt     = 0;
    clrCnt       = 0;
    beepCnt      = 0;
    prog.opDelay = 0;
    tick(n);
    rstn = 1'b1;
  endtask : doReset

  task automatic waitPh(input logic [6:0] p);
    int i = 0;
    while (fetchPhase !== p && i < 400) begin
      tick(1);
      i++;
    end
    check("fetchPhase", {1'b0, fetchPhase}, {1'b0, p});
  endtask : waitPh

  task automatic t_jumps();
    doReset(3);
    ld(1, pump_seq_pkg::OP_COND_JUMP, 8'h10);
    ld(2, pump_seq_pkg::OP_JUMP, 8'h20);
    progInPin = 1'b0;
    tick(3);
    pulse(progStart);
    waitPh(7'h10);
    progInPin = 1'b1;
    tick(4);
    pulse(progStart);
    waitPh(7'h02);
    waitPh(7'h20);
  endtask : t_jumps

  task automatic t_outputs();
    doReset(3);
    ld(1, pump_seq_pkg::OP_SET_OUTPUT, 8'h01);
    ld(2, pump_seq_pkg::OP_CLEAR_TOTAL, 8'h00);
    ld(3, pump_seq_pkg::OP_BEEP, 8'h00);
    ld(4, pump_seq_pkg::OP_PUMP, 8'h00);
    ld(5, pump_seq_pkg::OP_SET_OUTPUT, 8'h00);
    prog.opDelay = 12;
    pulse(progStart);
    waitPh(7'h02);
    check("progOutPin", {7'h00, progOutPin}, 8'h01);
    waitPh(7'h05);
    tick(4);
    check("progOutPin", {7'h00, progOutPin}, 8'h00);
    check("clearTotals", clrCnt[7:0], 8'h01);
    check("buzzer", beepCnt[7:0], 8'h05);
  endtask : t_outputs

  task automatic t_traps();
    doReset(3);
    ld(1, pump_seq_pkg::OP_LEVEL_TRAP, 8'h09);
    ld(2, pump_seq_pkg::OP_PUMP, 8'h00);
    ld(9, pump_seq_pkg::OP_ANY_TRAP, 8'h0c);
    ld(10, pump_seq_pkg::OP_PUMP, 8'h00);
    ld(12, pump_seq_pkg::OP_LEVEL_TRAP, 8'h1e);
    ld(13, pump_seq_pkg::OP_ANY_TRAP, 8'h14);
    ld(14, pump_seq_pkg::OP_PUMP, 8'h00);
    ld(20, pump_seq_pkg::OP_PUMP, 8'h00);
    pulse(progStart);
    waitPh(7'h02);
    eventTrigPin = 1'b0;
    waitPh(7'h09);
    waitPh(7'h0a);
    eventTrigPin = 1'b1;
    waitPh(7'h0c);
    waitPh(7'h0e);
    tick(3);
    pulse(remoteEvent);
    waitPh(7'h14);
    eventTrigPin = 1'b0;
    tick(8);
    check("fetchPhase", {1'b0, fetchPhase}, 8'h14);
    check("pumpAbort", abortCnt[7:0], 8'h03);
    eventTrigPin = 1'b1;
  endtask : t_traps

  task automatic t_lowhold();
    doReset(3);
    ld(1, pump_seq_pkg::OP_LEVEL_TRAP, 8'h07);
    ld(2, pump_seq_pkg::OP_PUMP, 8'h00);
    ld(7, pump_seq_pkg::OP_PUMP, 8'h00);
    eventTrigPin = 1'b0;
    tick(30);
    pulse(progStart);
    waitPh(7'h07);
    eventTrigPin = 1'b1;
  endtask : t_lowhold

  task automatic t_redirect();
    doReset(3);
    ld(1, pump_seq_pkg::OP_LEVEL_TRAP, 8'h09);
    ld(2, pump_seq_pkg::OP_REDIRECT, 8'h00);
    ld(3, pump_seq_pkg::OP_TRIG_MODE, 8'h33);
    ld(4, pump_seq_pkg::OP_PUMP, 8'h00);
    ld(9, pump_seq_pkg::OP_PUMP, 8'h00);
    pulse(progStart);
    waitPh(7'h04);
    check("trigMode", trigMode, 8'h33);
    tick(3);
    pulse(opTrigStop);
    waitPh(7'h09);
    check("trigMode", trigMode, 8'h33);
    tick(3);
    pulse(opTrigStop);
    tick(3);
    check("running", {7'h00, running}, 8'h00);
    pulse(progStart);
    tick(1);
    check("trigMode", trigMode, 8'h05);
    doReset(3);
    ld(1, pump_seq_pkg::OP_REDIRECT, 8'h00);
    ld(2, pump_seq_pkg::OP_PUMP, 8'h00);
    ld(3, pump_seq_pkg::OP_PUMP, 8'h00);
    pulse(progStart);
    waitPh(7'h02);
    tick(3);
    pulse(opTrigStop);
    waitPh(7'h03);
    tick(2);
    check("running", {7'h00, running}, 8'h01);
  endtask : t_redirect

  task automatic t_disarm();
    doReset(3);
    ld(1, pump_seq_pkg::OP_ANY_TRAP, 8'h09);
    ld(2, pump_seq_pkg::OP_TRAP_DISARM, 8'h00);
    ld(3, pump_seq_pkg::OP_PUMP, 8'h00);
    pulse(progStart);
    waitPh(7'h03);
    tick(3);
    pulse(remoteEvent);
    tick(3);
    check("fetchPhase", {1'b0, fetchPhase}, 8'h03);
    check("pumpAbort", abortCnt[7:0], 8'h00);
    pulse(progStop);
    tick(2);
    check("running", {7'h00, running}, 8'h00);
    check("pumpAbort", abortCnt[7:0], 8'h01);
  endtask : t_disarm

  initial begin
    doReset(16);
    t_jumps();
    t_outputs();
    t_traps();
    t_lowhold();
    t_redirect();
    t_disarm();
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
